/* hw/boot_config_vector_capture.sv */
// Boot configuration vector capture, override, register file and held-reset control.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module boot_config_vector_capture
	import boot_cfg_pkg::*;
(
	// Clock and bus reset.
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Reset source and power-on indication.
	input  wire logic             fundamental_reset_n,
	input  wire logic             power_on_pending,
	// Board straps.
	input  wire boot_vec_t        strap_in,
	// Override from EEPROM or slave SMBus during fundamental reset.
	input  wire strap_override_t  strap_override,
	// EEPROM register load port.
	input  wire logic             eeprom_wr_valid,
	input  wire logic [7:0]       eeprom_wr_addr,
	input  wire logic [31:0]      eeprom_wr_data,
	// AXI4-Lite write address channel.
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Applied configuration to the switch.
	output logic [2:0]            lane_reverse_out,
	output logic                  switch_held_in_reset,
	output logic [3:0]            switch_mode_out,
	output logic                  smbus_clk_enable,
	output logic                  slot_clk_upstream,
	output logic [1:0]            slot_clk_downstream
);

	localparam logic [1:0] resp_okay   = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequencing.

	// Fundamental reset state as seen last cycle, used to find the release edge.
	logic      perst_n_reg;
	// Applied strap vector, held until the next fundamental reset.
	boot_vec_t applied_reg;
	// Strap values of the most recent cold reset.
	boot_vec_t cold_reg;
	// Set once a cold record exists.
	logic      cold_valid_reg;
	// Power-on seen, turns the next fundamental reset into a cold one.
	logic      cold_pending_reg;
	// Control register and link status slot clock bits.
	logic [3:0] control_reg;
	logic      slot_us_reg;
	logic [1:0] slot_ds_reg;
	// SSC permission computed from the applied clock straps.
	logic      ssc_allowed;
	logic      release_edge;

	// The release edge is the first cycle with reset high after a low cycle.
	assign release_edge = fundamental_reset_n & ~perst_n_reg;
	// Spread spectrum is only safe with common clock on both sides; the board owns the actual switch.
	assign ssc_allowed = applied_reg.common_clk_upstream & applied_reg.common_clk_downstream;

	// Track the fundamental reset level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			perst_n_reg <= 1'b0;
		end else begin
			perst_n_reg <= fundamental_reset_n;
		end
	end

	// Remember power-on so the next release counts as cold; a release always consumes the mark, else a warm one turns cold.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cold_pending_reg <= 1'b0;
		end else if (release_edge) begin
			cold_pending_reg <= 1'b0;
		end else if (power_on_pending) begin
			cold_pending_reg <= 1'b1;
		end
	end

	// Capture at the release edge; strap pins are ignored at all other times.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			applied_reg <= boot_vec_reset;
		end else if (release_edge) begin
			applied_reg <= strap_in;
			if (strap_override.valid) begin
				// Mode, slow and refclk fields are never taken from the override.
				applied_reg.common_clk_upstream   <= strap_override.common_clk_upstream;
				applied_reg.common_clk_downstream <= strap_override.common_clk_downstream;
				applied_reg.port_a_lane_reverse   <= strap_override.port_a_lane_reverse;
				applied_reg.port_b_lane_reverse   <= strap_override.port_b_lane_reverse;
				applied_reg.port_c_lane_reverse   <= strap_override.port_c_lane_reverse;
				applied_reg.hold_in_reset         <= strap_override.hold_in_reset;
			end
		end
	end

	// The cold record takes the raw straps, not the overridden ones.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cold_reg       <= boot_vec_reset;
			cold_valid_reg <= 1'b0;
		end else if (release_edge && (cold_pending_reg || power_on_pending)) begin
			cold_reg       <= strap_in;
			cold_valid_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        do_write;

	// Merge byte lanes into an old word.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
	                                            input logic [3:0] strb);
		logic [31:0] result;
		result = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return result;
	endfunction

	// Decide whether an address maps to a register.
	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == switch_status_off) || (addr == switch_control_off) ||
		       (addr == upstream_link_sts_off) || (addr == port_b_link_sts_off) ||
		       (addr == port_c_link_sts_off) || (addr == clock_config_off) || (addr == eeprom_load_off);
	endfunction

	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

	// Address and data are taken in either order and held until the write fires.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response follows the register update.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_addr_reg) ? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control and link status registers.

	logic [31:0] ctl_word;
	logic [31:0] ctl_merged;
	logic [31:0] us_merged;
	logic [31:0] b_merged;
	logic [31:0] c_merged;
	logic        ee_ctl;
	logic        ee_us;
	logic        ee_b;
	logic        ee_c;

	assign ctl_word   = {28'h0, control_reg};
	assign ctl_merged = merge_bytes(ctl_word, w_data_reg, w_strb_reg);
	assign us_merged  = merge_bytes(32'(slot_us_reg) << slot_clk_bit, w_data_reg, w_strb_reg);
	assign b_merged   = merge_bytes(32'(slot_ds_reg[0]) << slot_clk_bit, w_data_reg, w_strb_reg);
	assign c_merged   = merge_bytes(32'(slot_ds_reg[1]) << slot_clk_bit, w_data_reg, w_strb_reg);
	// The EEPROM loader writes full words and wins over a bus write in the same cycle.
	assign ee_ctl = eeprom_wr_valid && (eeprom_wr_addr == switch_control_off);
	assign ee_us  = eeprom_wr_valid && (eeprom_wr_addr == upstream_link_sts_off);
	assign ee_b   = eeprom_wr_valid && (eeprom_wr_addr == port_b_link_sts_off);
	assign ee_c   = eeprom_wr_valid && (eeprom_wr_addr == port_c_link_sts_off);

	// Switch control: loaded from straps at release, then software or EEPROM owns it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg <= 4'h0;
		end else if (release_edge) begin
			control_reg[lane_reverse_a_bit] <= release_lrev(0);
			control_reg[lane_reverse_b_bit] <= release_lrev(1);
			control_reg[lane_reverse_c_bit] <= release_lrev(2);
			control_reg[hold_in_reset_bit]  <= strap_override.valid ? strap_override.hold_in_reset
			                                                          : strap_in.hold_in_reset;
		end else if (ee_ctl) begin
			control_reg <= eeprom_wr_data[3:0];
		end else if (do_write && aw_addr_reg == switch_control_off) begin
			control_reg <= ctl_merged[3:0];
		end
	end

	// Lane-reverse value applied at release, override taking precedence.
	function automatic logic release_lrev(input int idx);
		logic [2:0] pins;
		logic [2:0] ovr;
		pins = {strap_in.port_c_lane_reverse, strap_in.port_b_lane_reverse, strap_in.port_a_lane_reverse};
		ovr  = {strap_override.port_c_lane_reverse, strap_override.port_b_lane_reverse,
		        strap_override.port_a_lane_reverse};
		return strap_override.valid ? ovr[idx] : pins[idx];
	endfunction

	// Slot clock bits start from the common-clock straps and are writable later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_us_reg <= 1'b0;
			slot_ds_reg <= 2'b00;
		end else if (release_edge) begin
			slot_us_reg <= strap_override.valid ? strap_override.common_clk_upstream
			                                    : strap_in.common_clk_upstream;
			slot_ds_reg <= {2{strap_override.valid ? strap_override.common_clk_downstream
			                                       : strap_in.common_clk_downstream}};
		end else begin
			if (ee_us || (do_write && aw_addr_reg == upstream_link_sts_off)) begin
				slot_us_reg <= ee_us ? eeprom_wr_data[slot_clk_bit] : us_merged[slot_clk_bit];
			end
			if (ee_b || (do_write && aw_addr_reg == port_b_link_sts_off)) begin
				slot_ds_reg[0] <= ee_b ? eeprom_wr_data[slot_clk_bit] : b_merged[slot_clk_bit];
			end
			if (ee_c || (do_write && aw_addr_reg == port_c_link_sts_off)) begin
				slot_ds_reg[1] <= ee_c ? eeprom_wr_data[slot_clk_bit] : c_merged[slot_clk_bit];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel.

	logic [31:0] status_word;
	logic [31:0] clock_word;

	// Status shows the cold record, cold flag and the held state.
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[sts_refclk_bit]              = cold_reg.refclk_freq_select;
		status_word[sts_ccus_bit]                = cold_reg.common_clk_upstream;
		status_word[sts_ccds_bit]                = cold_reg.common_clk_downstream;
		status_word[sts_slow_bit]                = cold_reg.master_smbus_slow_strap;
		status_word[sts_lrev_a_bit]              = cold_reg.port_a_lane_reverse;
		status_word[sts_lrev_b_bit]              = cold_reg.port_b_lane_reverse;
		status_word[sts_lrev_c_bit]              = cold_reg.port_c_lane_reverse;
		status_word[sts_hold_bit]                = cold_reg.hold_in_reset;
		status_word[sts_mode_lsb +: 4]           = cold_reg.switch_op_mode;
		status_word[sts_cold_bit]                = cold_valid_reg;
		status_word[sts_halted_bit]              = switch_held_in_reset;
	end

	// Clock register reports reference and core frequencies and SSC permission.
	always_comb begin
		clock_word = 32'h0000_0000;
		clock_word[clk_ssc_allowed_bit]  = ssc_allowed;
		clock_word[clk_ref_mhz_lsb +: 8] = applied_reg.refclk_freq_select ? refclk_high_mhz
		                                                                  : refclk_low_mhz;
		clock_word[clk_core_mhz_lsb +: 8] = core_clk_mhz;
	end

	// Reads answer one cycle after the address is taken; unmapped gives SLVERR and zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= resp_okay;
				if (s_axi_araddr == switch_status_off) begin
					s_axi_rdata <= status_word;
				end else if (s_axi_araddr == switch_control_off) begin
					s_axi_rdata <= ctl_word;
				end else if (s_axi_araddr == upstream_link_sts_off) begin
					s_axi_rdata <= 32'(slot_us_reg) << slot_clk_bit;
				end else if (s_axi_araddr == port_b_link_sts_off) begin
					s_axi_rdata <= 32'(slot_ds_reg[0]) << slot_clk_bit;
				end else if (s_axi_araddr == port_c_link_sts_off) begin
					s_axi_rdata <= 32'(slot_ds_reg[1]) << slot_clk_bit;
				end else if (s_axi_araddr == clock_config_off) begin
					s_axi_rdata <= clock_word;
				end else if (s_axi_araddr == eeprom_load_off) begin
					s_axi_rdata <= 32'(applied_reg.switch_op_mode);
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= resp_slverr;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Applied outputs and SMBus rate divider.

	logic [9:0] smb_cnt_reg;
	logic [9:0] smb_div;

	// Slow strap picks the 100 kHz divider, otherwise 400 kHz.
	assign smb_div = applied_reg.master_smbus_slow_strap ? smbus_slow_div : smbus_fast_div;

	// Divider produces a one-cycle enable at twice the SMBus bit rate.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smb_cnt_reg      <= 10'h000;
			smbus_clk_enable <= 1'b0;
		end else if (smb_cnt_reg >= smb_div - 10'h001) begin
			smb_cnt_reg      <= 10'h000;
			smbus_clk_enable <= 1'b1;
		end else begin
			smb_cnt_reg      <= smb_cnt_reg + 10'h001;
			smbus_clk_enable <= 1'b0;
		end
	end

	// Switch held in reset while fundamental reset is low or the hold bit is set; SMBus stays alive.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			switch_held_in_reset <= 1'b1;
			lane_reverse_out     <= 3'b000;
			switch_mode_out      <= 4'h0;
			slot_clk_upstream    <= 1'b0;
			slot_clk_downstream  <= 2'b00;
		end else begin
			switch_held_in_reset <= !fundamental_reset_n || !perst_n_reg || control_reg[hold_in_reset_bit];
			lane_reverse_out     <= control_reg[lane_reverse_c_bit:lane_reverse_a_bit];
			switch_mode_out      <= applied_reg.switch_op_mode;
			slot_clk_upstream    <= slot_us_reg;
			slot_clk_downstream  <= slot_ds_reg;
		end
	end

endmodule

`default_nettype wire

/* pkg/boot_cfg_pkg.sv */
// Package with register map, field layout, strap vector type and timing constants for the boot configuration block.
`default_nettype none
package boot_cfg_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] switch_status_off      = 8'h00;
	localparam logic [7:0] switch_control_off     = 8'h04;
	localparam logic [7:0] upstream_link_sts_off  = 8'h08;
	localparam logic [7:0] port_b_link_sts_off    = 8'h0c;
	localparam logic [7:0] port_c_link_sts_off    = 8'h10;
	localparam logic [7:0] clock_config_off       = 8'h14;
	localparam logic [7:0] eeprom_load_off        = 8'h18;

	// Switch control field positions.
	localparam int lane_reverse_a_bit = 0;
	localparam int lane_reverse_b_bit = 1;
	localparam int lane_reverse_c_bit = 2;
	localparam int hold_in_reset_bit  = 3;

	// Slot clock configuration bit in each link status register.
	localparam int slot_clk_bit = 12;

	// Switch status field positions (one per strap, mode in a nibble).
	localparam int sts_refclk_bit  = 0;
	localparam int sts_ccus_bit    = 1;
	localparam int sts_ccds_bit    = 2;
	localparam int sts_slow_bit    = 3;
	localparam int sts_lrev_a_bit  = 4;
	localparam int sts_lrev_b_bit  = 5;
	localparam int sts_lrev_c_bit  = 6;
	localparam int sts_hold_bit    = 7;
	localparam int sts_mode_lsb    = 8;
	localparam int sts_cold_bit    = 12;
	localparam int sts_halted_bit  = 13;

	// Clock config register fields.
	localparam int clk_ssc_allowed_bit = 0;
	localparam int clk_ref_mhz_lsb     = 8;
	localparam int clk_core_mhz_lsb    = 16;

	// Clock figures in MHz and kHz.
	localparam logic [7:0]  refclk_low_mhz   = 8'd100;
	localparam logic [7:0]  refclk_high_mhz  = 8'd125;
	localparam logic [11:0] lane_clk_mhz     = 12'd2500;
	localparam logic [7:0]  core_clk_mhz     = 8'd250;
	localparam int          lanes_per_gen    = 4;
	localparam int          smbus_slow_khz   = 100;
	localparam int          smbus_fast_khz   = 400;
	localparam int          aclk_khz         = 125000;
	// Half-periods of the SCL enable divider, derived from the rates.
	localparam logic [9:0]  smbus_slow_div   = 10'(aclk_khz / (2 * smbus_slow_khz));
	localparam logic [9:0]  smbus_fast_div   = 10'(aclk_khz / (2 * smbus_fast_khz));

	// Switch mode codes.
	typedef enum logic [3:0] {
		mode_nt          = 4'h2,
		mode_nt_eeprom   = 4'h3,
		mode_failover    = 4'h4,
		mode_failover_ee = 4'h5
	} switch_op_mode_t;

	// Boot configuration vector carried as one packed struct.
	typedef struct packed {
		logic       refclk_freq_select;
		logic       common_clk_upstream;
		logic       common_clk_downstream;
		logic       master_smbus_slow_strap;
		logic       port_a_lane_reverse;
		logic       port_b_lane_reverse;
		logic       port_c_lane_reverse;
		logic       hold_in_reset;
		logic [3:0] switch_op_mode;
	} boot_vec_t;

	localparam boot_vec_t boot_vec_reset = '0;

	// Override request from EEPROM or slave SMBus.
	typedef struct packed {
		logic       valid;
		logic       common_clk_upstream;
		logic       common_clk_downstream;
		logic       port_a_lane_reverse;
		logic       port_b_lane_reverse;
		logic       port_c_lane_reverse;
		logic       hold_in_reset;
	} strap_override_t;

endpackage
`default_nettype wire

/* tb/boot_cfg_monitor.sv */
// Concurrent checks on the ports of the boot configuration block.
`timescale 1ns/10ps
`default_nettype none
module boot_cfg_monitor
	import boot_cfg_pkg::*;
(
	// Clock and reset.
	input wire logic            aclk,
	input wire logic            aresetn,
	// Reset source and straps.
	input wire logic            fundamental_reset_n,
	input wire boot_vec_t       strap_in,
	input wire strap_override_t strap_override,
	// Applied configuration.
	input wire logic [2:0]      lane_reverse_out,
	input wire logic            switch_held_in_reset,
	input wire logic [3:0]      switch_mode_out,
	input wire logic            smbus_clk_enable,
	input wire logic            slot_clk_upstream,
	input wire logic [1:0]      slot_clk_downstream
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Lane bits gathered in output order, bit 0 for port A.
	wire logic [2:0] pin_lanes = {strap_in.port_c_lane_reverse, strap_in.port_b_lane_reverse,
		strap_in.port_a_lane_reverse};
	wire logic [2:0] ov_lanes = {strap_override.port_c_lane_reverse, strap_override.port_b_lane_reverse,
		strap_override.port_a_lane_reverse};
	////////////////////////////////////////
	// Release edges; outputs have settled three edges later, since capture and output are both registered.
	sequence s_rel;
		$rose(fundamental_reset_n) ##0 !strap_override.valid;
	endsequence
	sequence s_rel_ov;
		$rose(fundamental_reset_n) ##0 strap_override.valid;
	endsequence
	property p_mode;
		$rose(fundamental_reset_n) |-> ##3 switch_mode_out == $past(strap_in.switch_op_mode, 3);
	endproperty
	a_mode: assert property (p_mode) else $error("mode not taken from pins");
	property p_lanes;
		s_rel |-> ##3 lane_reverse_out == $past(pin_lanes, 3);
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane reverse not captured");
	property p_override;
		s_rel_ov |-> ##3 lane_reverse_out == $past(ov_lanes, 3)
			&& slot_clk_upstream == $past(strap_override.common_clk_upstream, 3);
	endproperty
	a_override: assert property (p_override) else $error("override not applied");
	property p_slot;
		s_rel |-> ##3 slot_clk_upstream == $past(strap_in.common_clk_upstream, 3)
			&& slot_clk_downstream == {2{$past(strap_in.common_clk_downstream, 3)}};
	endproperty
	a_slot: assert property (p_slot) else $error("slot clock bits wrong");
	property p_in_reset;
		!fundamental_reset_n |=> switch_held_in_reset;
	endproperty
	a_in_reset: assert property (p_in_reset) else $error("switch ran during reset");
	property p_hold;
		s_rel ##0 strap_in.hold_in_reset |-> ##3 switch_held_in_reset [*4];
	endproperty
	a_hold: assert property (p_hold) else $error("hold strap ignored");
	property p_run;
		s_rel ##0 !strap_in.hold_in_reset |-> ##3 !switch_held_in_reset;
	endproperty
	a_run: assert property (p_run) else $error("switch stuck in reset");
	property p_stable;
		fundamental_reset_n && $past(fundamental_reset_n) && $past(fundamental_reset_n, 2)
			&& $past(fundamental_reset_n, 3) |-> $stable(switch_mode_out);
	endproperty
	a_stable: assert property (p_stable) else $error("mode moved outside reset");
	property p_pulse;
		smbus_clk_enable |=> !smbus_clk_enable [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("bus clock enable too dense");
endmodule
bind boot_config_vector_capture boot_cfg_monitor mon (.aclk, .aresetn, .fundamental_reset_n, .strap_in,
	.strap_override, .lane_reverse_out, .switch_held_in_reset, .switch_mode_out,
	.smbus_clk_enable, .slot_clk_upstream, .slot_clk_downstream);
`default_nettype wire

/* tb/strap_board_model.sv */
// Board side model: strap pins, override source and the fundamental reset line.
`timescale 1ns/10ps
`default_nettype none
module strap_board_model
	import boot_cfg_pkg::*;
(
	// Board clock reference.
	input wire logic        aclk,
	// Reset source and straps.
	output logic            fundamental_reset_n,
	output logic            power_on_pending,
	output boot_vec_t       strap_in,
	output strap_override_t strap_override
);
	// Power comes up with the part in reset and a legal mode strapped.
	initial begin
		fundamental_reset_n = 1'h0;
		power_on_pending = 1'h1;
		strap_in = boot_vec_t'(12'h002);
		strap_override = '0;
	end
	////////////////////////////////////////
	// One fundamental reset; pins stay put across the release, the override lasts one edge past it.
	task automatic pulse_reset(input boot_vec_t s, input strap_override_t o, input logic cold);
		@(posedge aclk);
		fundamental_reset_n <= 1'h0;
		power_on_pending <= cold;
		// A mode outside 2 to 5 is replaced by mode 2 on the pins; the other strap fields pass as given.
		strap_in <= (s.switch_op_mode inside {[4'h2:4'h5]}) ? s : boot_vec_t'({s[11:4], 4'h2});
		strap_override <= o;
		repeat (4) @(posedge aclk);
		fundamental_reset_n <= 1'h1;
		@(posedge aclk);
		strap_override <= '0;
		power_on_pending <= 1'h0;
		repeat (4) @(posedge aclk);
	endtask
	// Pins that move in normal operation must be ignored.
	task automatic wiggle(input boot_vec_t s);
		@(posedge aclk);
		strap_in <= s;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the boot configuration block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import boot_cfg_pkg::*;
	// One row: straps and override beside the lanes, slot bits and upstream slot bit they give.
	typedef struct packed {
		boot_vec_t       s;
		strap_override_t o;
		logic [2:0]      lr;
		logic [1:0]      sd;
		logic            su;
	} row_t;
	row_t            rows [4] = '{'{12'h5a2, 7'h00, 3'h5, 2'h0, 1'h1}, '{12'ha43, 7'h00, 3'h2, 2'h3, 1'h0},
		'{12'h1c4, 7'h72, 3'h4, 2'h3, 1'h1}, '{12'hfe5, 7'h00, 3'h7, 2'h3, 1'h1}};
	logic            aclk = 1'h0;
	logic            aresetn = 1'h0;
	logic            fundamental_reset_n, power_on_pending;
	boot_vec_t       strap_in;
	strap_override_t strap_override;
	logic            eeprom_wr_valid = 1'h0;
	logic [7:0]      eeprom_wr_addr = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]     eeprom_wr_data = '0, s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]      s_axi_wstrb = 4'hf;
	logic            s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic            s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]      s_axi_bresp, s_axi_rresp, slot_clk_downstream;
	logic [2:0]      lane_reverse_out;
	logic [3:0]      switch_mode_out;
	logic            switch_held_in_reset, smbus_clk_enable, slot_clk_upstream;
	int              error_cnt = 0, n_compared = 0, cycles = 0;
	boot_config_vector_capture dut (.*);
	strap_board_model board (.*);
	always #4 aclk = ~aclk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Status layout: pins in bits 7..0 from refclk upward, mode above, cold record flag at bit 12.
	function automatic logic [31:0] stat(input boot_vec_t s);
		stat = {19'h0, 1'h1, s[3:0], 8'h0};
		for (int i = 0; i < 8; i++) stat[i] = s[11-i];
	endfunction
	// Write and read each wait for the slave's answer; the global counter cuts a hang.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(32'(s_axi_bresp), 32'(rsp));
		repeat (2) @(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d);
		chk(32'(s_axi_rresp), 32'(rsp));
	endtask
	// A full-word load beat from the serial memory.
	task automatic ee(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		eeprom_wr_valid <= 1'h1;
		eeprom_wr_addr <= a;
		eeprom_wr_data <= d;
		@(posedge aclk);
		eeprom_wr_valid <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	// Cycles from one bus clock enable to the next.
	task automatic period(input logic [31:0] exp);
		int n;
		n = 0;
		@(posedge aclk iff smbus_clk_enable);
		do begin
			@(posedge aclk);
			n++;
		end while (!smbus_clk_enable && n < 2000);
		chk(n, exp);
	endtask
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// The whole run needs at most about four thousand cycles.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			board.pulse_reset(rows[i].s, rows[i].o, 1'h1);
			chk(32'(lane_reverse_out), 32'(rows[i].lr));
			chk(32'(switch_mode_out), 32'(rows[i].s.switch_op_mode));
			chk(32'({slot_clk_upstream, slot_clk_downstream}), 32'({rows[i].su, rows[i].sd}));
			chk(32'(switch_held_in_reset), 32'h0);
			rd(switch_status_off, stat(rows[i].s), 2'h0);
			rd(clock_config_off, {8'h0, core_clk_mhz, rows[i].s.refclk_freq_select ? refclk_high_mhz : refclk_low_mhz,
				7'h0, rows[i].su & rows[i].sd[0]}, 2'h0);
			period(rows[i].s.master_smbus_slow_strap ? 32'(smbus_slow_div) : 32'(smbus_fast_div));
			board.wiggle({~rows[i].s[11:4], rows[i].s[3:0]});
			repeat (3) @(posedge aclk);
			chk(32'(lane_reverse_out), 32'(rows[i].lr));
		end
		// A warm reset with the hold strap keeps the last cold record and parks the switch.
		board.pulse_reset(boot_vec_t'(12'h0f2), '0, 1'h0);
		chk(32'(switch_held_in_reset), 32'h1);
		rd(switch_status_off, stat(rows[3].s) | 32'h2000, 2'h0);
		rd(switch_control_off, 32'hf, 2'h0);
		wr(switch_control_off, 32'h5, 2'h0);
		chk(32'(switch_held_in_reset), 32'h0);
		chk(32'(lane_reverse_out), 32'h5);
		wr(upstream_link_sts_off, 32'h1000, 2'h0);
		chk(32'(slot_clk_upstream), 32'h1);
		wr(port_b_link_sts_off, 32'h1000, 2'h0);
		chk(32'(slot_clk_downstream), 32'h1);
		ee(switch_control_off, 32'h2);
		chk(32'(lane_reverse_out), 32'h2);
		wr(eeprom_load_off, 32'h0, 2'h0);
		rd(eeprom_load_off, 32'h2, 2'h0);
		wr(8'h40, 32'h1, 2'h2);
		rd(8'h40, 32'h0, 2'h2);
		print_verdict();
	end
endmodule
`default_nettype wire
